// ### core/link_seq_pkg.sv
// constants and types shared by the pixel link sequencer
package link_seq_pkg;

	// system clock and pixel clock timing
	localparam int MCLK_PERIOD_NS     = 8;
	localparam int PCLK_MIN_PERIOD_NS = 200;
	localparam int STOP_GAP_PCLK      = 4;
	localparam int STOP_GAP_CYC       =
		(STOP_GAP_PCLK * PCLK_MIN_PERIOD_NS + MCLK_PERIOD_NS - 1)
		/ MCLK_PERIOD_NS;

	// start-up intervals in pixel-clock cycles
	localparam int             SEQ_CNT_W = 10;
	localparam logic [9:0] BIAS_CYC  = 10'h0c8;
	localparam logic [9:0] LOW1_CYC  = 10'h0c8;
	localparam logic [9:0] HIGH_CYC  = 10'h014;
	localparam logic [9:0] LOW2_CYC  = 10'h008;
	localparam logic [9:0] LOCK_CYC  = 10'h258;

	// serial word layout
	localparam int         WORD_W      = 24;
	localparam int         LANES_MAX   = 3;
	localparam int         COLOR_MSB   = 7;
	localparam int         COLOR_LSB   = 2;
	localparam logic [3:0] SLOTS_3LANE = 4'h8;
	localparam logic [3:0] SLOTS_2LANE = 4'hc;
	localparam logic [2:0] MASK_3LANE  = 3'h7;
	localparam logic [2:0] MASK_2LANE  = 3'h3;
	localparam int         BIT_CYC_DEF = 1;
	localparam int         FIFO_DEPTH  = 8;

	// phase as seen on the link outputs
	localparam logic [1:0] PHASE_OFF    = 2'h0;
	localparam logic [1:0] PHASE_LINKUP = 2'h1;
	localparam logic [1:0] PHASE_ACTIVE = 2'h2;

	// sequencer states, gray ordered along the start-up path
	typedef enum logic [2:0]
	{
		PH_OFF    = 3'b000,
		PH_BIAS   = 3'b001,
		PH_LOW1   = 3'b011,
		PH_HIGH   = 3'b010,
		PH_LOW2   = 3'b110,
		PH_LOCK   = 3'b111,
		PH_ACTIVE = 3'b101
	} link_phase_e;

endpackage

// ### core/link_fifo.sv
// word fifo with registered read data, valid and ready on both sides
`timescale 1ns/1ps
module link_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	input  wire logic             flush_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("link_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wptr_r;
	logic [AW-1:0]    rptr_r;
	logic [CW-1:0]    count_r;
	logic             push;
	logic             pop;

	// full refuses writes so the source sees back-pressure
	assign wr_ready_out = (count_r != FULL_CNT);
	assign push = wr_valid_in && wr_ready_out;
	assign pop  = (count_r != '0) && (!rd_valid_out || rd_ready_in);

	always_ff @(posedge clk_in)
	begin
		if (push)
			mem_r[wptr_r] <= wr_data_in;
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wptr_r  <= '0;
			rptr_r  <= '0;
			count_r <= '0;
		end
		else if (flush_in)
		begin
			wptr_r  <= '0;
			rptr_r  <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wptr_r <= AW'(wptr_r + 1'b1);
			if (pop)
				rptr_r <= AW'(rptr_r + 1'b1);
			count_r <= CW'(count_r + CW'(push) - CW'(pop));
		end
	end

	// output stage register holds the head word
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rd_valid_out <= 1'b0;
			rd_data_out  <= '0;
		end
		else if (flush_in)
			rd_valid_out <= 1'b0;
		else if (pop)
		begin
			rd_valid_out <= 1'b1;
			rd_data_out  <= mem_r[rptr_r];
		end
		else if (rd_ready_in)
			rd_valid_out <= 1'b0;
	end
endmodule

// ### core/serial_pixel_link_phase_sequencer.sv
// link phase sequencer and serializer for a current-mode pixel link
`timescale 1ns/1ps
// Behaviour
// (R1) off phase: every line driver carries no current
// (R2) power-up starts with bias interval
// (R3) then clock line low 200 pixel clocks
// (R4) then clock line high 20 pixel clocks
// (R5) then clock line low 8 pixel clocks
// (R6) 600-cycle lock hold-off before streaming pixels
// (R7) phases off, link-up, active; active exits off
// (R8) stopped pixel clock resets the sequencer
// (R9) returning clock reruns full start-up sequence
// (R10) power-down or clock stop forces off, low power
// (R11) rgb plus syncs and valid serialized on lanes
// (R12) eight slots three lanes, twelve two lanes
// (R13) line states off, low 5I, high 1I
// (R14) data launched on both clock line edges
// (R15) receiver powers up on first low current
// (R16) receiver calibrates on low-to-high transition
// (R17) data lines off, then low in last interval
// (R18) pixel-clock counters cleared by power-down, stop
module serial_pixel_link_phase_sequencer
	import link_seq_pkg::*;
#(
	parameter int BIT_CYC  = BIT_CYC_DEF,
	parameter int STOP_GAP = STOP_GAP_CYC,
	parameter int FDEPTH   = FIFO_DEPTH
) (
	input  wire logic       mclk_in,
	input  wire logic       arst_n_in,
	input  wire logic       pclk_in,
	input  wire logic       power_down_n_in,
	input  wire logic       three_lane_in,
	input  wire logic [7:0] red_in,
	input  wire logic [7:0] green_in,
	input  wire logic [7:0] blue_in,
	input  wire logic       vertical_sync_in,
	input  wire logic       horizontal_sync_in,
	input  wire logic       pixel_valid_in,
	output logic            link_clock_line_on_out,
	output logic            link_clock_line_lvl_out,
	output logic [2:0]      link_data_line_on_out,
	output logic [2:0]      link_data_line_lvl_out,
	output logic [1:0]      link_phase_out,
	output logic            bias_en_out,
	output logic            low_power_out,
	output logic            overflow_out
);
	localparam int GAP_W = $clog2(STOP_GAP + 1);
	localparam int BC_W  = $clog2(BIT_CYC + 1);
	localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(STOP_GAP - 1);
	localparam logic [BC_W-1:0]  BIT_LAST = BC_W'(BIT_CYC - 1);

	if (BIT_CYC < 1 || STOP_GAP < 2 || FDEPTH < 2)
	begin : g_bad_param
		$error("bit time, stop gap or fifo depth too small");
	end

	function automatic logic [9:0] seq_len(input link_phase_e ph);
		case (ph)
			PH_BIAS: seq_len = BIAS_CYC;
			PH_LOW1: seq_len = LOW1_CYC;
			PH_HIGH: seq_len = HIGH_CYC;
			PH_LOW2: seq_len = LOW2_CYC;
			PH_LOCK: seq_len = LOCK_CYC;
			default: seq_len = 10'h001;
		endcase
	endfunction

	function automatic link_phase_e seq_next(input link_phase_e ph);
		case (ph)
			PH_OFF:  seq_next = PH_BIAS;
			PH_BIAS: seq_next = PH_LOW1;
			PH_LOW1: seq_next = PH_HIGH;
			PH_HIGH: seq_next = PH_LOW2;
			PH_LOW2: seq_next = PH_LOCK;
			PH_LOCK: seq_next = PH_ACTIVE;
			default: seq_next = PH_ACTIVE;
		endcase
	endfunction

	// lane 0 carries the msb of each slot group
	function automatic logic [2:0] lane_bits(input logic [WORD_W-1:0] w,
		input logic three);
		lane_bits = {three & w[WORD_W-3], w[WORD_W-2], w[WORD_W-1]};
	endfunction

	// system clock domain synchronisers
	logic             pwr_meta_r;
	logic             pwr_sync_r;
	logic             lane_meta_r;
	logic             lane_sync_r;
	logic             ptog_meta_r;
	logic             ptog_sync_r;
	logic             ptog_last_r;
	logic             xtog_meta_r;
	logic             xtog_sync_r;
	logic             xtog_last_r;
	logic [2:0]       ph_meta_r;
	logic [2:0]       ph_sync_r;
	logic [2:0]       ph_prev_r;
	link_phase_e      ph_seen_r;
	logic [GAP_W-1:0] gap_cnt_r;
	logic             stopped_r;
	logic             link_down;
	link_phase_e      ph_eff;

	// pixel clock domain
	logic              prst_meta_r;
	logic              prst_r;
	logic              pix_rst_src_n;
	logic              pclk_tog_r;
	link_phase_e       phase_r;
	logic [9:0]        cnt_r;
	logic [WORD_W-1:0] pix_word_r;
	logic              pix_tog_r;

	// fifo and serializer
	logic              push_r;
	logic [WORD_W-1:0] push_data_r;
	logic              fifo_wr_ready;
	logic              fifo_rd_valid;
	logic              fifo_rd_ready;
	logic [WORD_W-1:0] fifo_rd_data;
	logic              three_r;
	logic [2:0]        lane_mask;
	logic [3:0]        slots;
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] shift_nxt;
	logic [3:0]        slot_r;
	logic [BC_W-1:0]   bit_cnt_r;
	logic              tick;
	logic              last_slot;

	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			pwr_meta_r  <= 1'b0;
			pwr_sync_r  <= 1'b0;
			lane_meta_r <= 1'b0;
			lane_sync_r <= 1'b0;
			ptog_meta_r <= 1'b0;
			ptog_sync_r <= 1'b0;
			ptog_last_r <= 1'b0;
			xtog_meta_r <= 1'b0;
			xtog_sync_r <= 1'b0;
			xtog_last_r <= 1'b0;
			ph_meta_r   <= PH_OFF;
			ph_sync_r   <= PH_OFF;
			ph_prev_r   <= PH_OFF;
		end
		else
		begin
			pwr_meta_r  <= power_down_n_in;
			pwr_sync_r  <= pwr_meta_r;
			lane_meta_r <= three_lane_in;
			lane_sync_r <= lane_meta_r;
			ptog_meta_r <= pclk_tog_r;
			ptog_sync_r <= ptog_meta_r;
			ptog_last_r <= ptog_sync_r;
			xtog_meta_r <= pix_tog_r;
			xtog_sync_r <= xtog_meta_r;
			xtog_last_r <= xtog_sync_r;
			ph_meta_r   <= phase_r;
			ph_sync_r   <= ph_meta_r;
			ph_prev_r   <= ph_sync_r;
		end
	end

	// phase code taken only once stable for two samples, so the
	// multi-bit jump from active back to off cannot mis-decode
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ph_seen_r <= PH_OFF;
		else if (ph_sync_r == ph_prev_r)
			ph_seen_r <= link_phase_e'(ph_sync_r);
	end

	// clock stop: no pixel clock edge for the gap counts as stopped
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			gap_cnt_r <= '0;
			stopped_r <= 1'b1;
		end
		else if (ptog_sync_r != ptog_last_r)
		begin
			gap_cnt_r <= '0;
			stopped_r <= 1'b0;
		end
		else if (gap_cnt_r == GAP_LAST)
			stopped_r <= 1'b1; // [R8]
		else
			gap_cnt_r <= GAP_W'(gap_cnt_r + 1'b1);
	end

	assign link_down = !pwr_sync_r || stopped_r;
	assign ph_eff = link_down ? PH_OFF : ph_seen_r; // [R10] [R7]

	// reset of the pixel domain: asserted at once, released on pclk
	assign pix_rst_src_n = arst_n_in && pwr_sync_r && !stopped_r;

	always_ff @(posedge pclk_in or negedge pix_rst_src_n)
	begin
		if (!pix_rst_src_n)
		begin
			prst_meta_r <= 1'b0;
			prst_r      <= 1'b0;
		end
		else
		begin
			prst_meta_r <= 1'b1;
			prst_r      <= prst_meta_r;
		end
	end

	// free-running toggle lets the system clock see pclk activity
	always_ff @(posedge pclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pclk_tog_r <= 1'b0;
		else
			pclk_tog_r <= !pclk_tog_r;
	end

	// start-up sequence counted in pixel clocks
	always_ff @(posedge pclk_in or negedge prst_r)
	begin
		if (!prst_r)
		begin
			phase_r <= PH_OFF; // [R18] [R9]
			cnt_r   <= '0;
		end
		else if (phase_r == PH_OFF)
		begin
			phase_r <= PH_BIAS; // [R2]
			cnt_r   <= '0;
		end
		else if (phase_r != PH_ACTIVE)
		begin
			if (cnt_r == 10'(seq_len(phase_r) - 10'h001))
			begin
				phase_r <= seq_next(phase_r); // [R3] [R4] [R5] [R6]
				cnt_r   <= '0;
			end
			else
				cnt_r <= 10'(cnt_r + 10'h001);
		end
	end

	// pixels captured only once the hold-off is over
	always_ff @(posedge pclk_in or negedge prst_r)
	begin
		if (!prst_r)
		begin
			pix_word_r <= '0;
			pix_tog_r  <= 1'b0;
		end
		else if (phase_r == PH_ACTIVE)
		begin
			pix_word_r <= {red_in[COLOR_MSB:COLOR_LSB],
				green_in[COLOR_MSB:COLOR_LSB],
				blue_in[COLOR_MSB:COLOR_LSB], vertical_sync_in,
				horizontal_sync_in, pixel_valid_in, 3'h0}; // [R11] [R6]
			pix_tog_r  <= !pix_tog_r;
		end
	end

	// word handshake: data stable for the toggle's sync latency
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			push_r      <= 1'b0;
			push_data_r <= '0;
		end
		else
		begin
			push_r <= (xtog_sync_r != xtog_last_r) && !link_down;
			if (xtog_sync_r != xtog_last_r)
				push_data_r <= pix_word_r;
		end
	end

	// pixels cannot be stalled at the source; a refused word is lost
	// and flagged until the link next passes through off
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			overflow_out <= 1'b0;
		else if (push_r && !fifo_wr_ready)
			overflow_out <= 1'b1;
		else if (ph_eff == PH_OFF)
			overflow_out <= 1'b0;
	end

	link_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FDEPTH)
	) u_fifo (
		.clk_in       (mclk_in),
		.arst_n_in    (arst_n_in),
		.flush_in     (ph_eff != PH_ACTIVE),
		.wr_valid_in  (push_r),
		.wr_ready_out (fifo_wr_ready),
		.wr_data_in   (push_data_r),
		.rd_valid_out (fifo_rd_valid),
		.rd_ready_in  (fifo_rd_ready),
		.rd_data_out  (fifo_rd_data)
	);

	// lane count only changes while the link is off
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			three_r <= 1'b0;
		else if (ph_eff == PH_OFF)
			three_r <= lane_sync_r;
	end

	assign lane_mask = three_r ? MASK_3LANE : MASK_2LANE;
	assign slots     = three_r ? SLOTS_3LANE : SLOTS_2LANE; // [R12]
	assign tick      = (bit_cnt_r == BIT_LAST);
	assign last_slot = (slot_r == 4'(slots - 4'h1));
	assign fifo_rd_ready = (ph_eff == PH_ACTIVE) && tick && last_slot;

	// an empty fifo sends an idle word with pixel valid low
	always_comb
	begin
		if (last_slot)
			shift_nxt = fifo_rd_valid ? fifo_rd_data : '0;
		else if (three_r)
			shift_nxt = {shift_r[WORD_W-4:0], 3'h0};
		else
			shift_nxt = {shift_r[WORD_W-3:0], 2'h0};
	end

	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			bit_cnt_r <= '0;
			slot_r    <= SLOTS_2LANE - 4'h1;
			shift_r   <= '0;
		end
		else if (ph_eff != PH_ACTIVE)
		begin
			bit_cnt_r <= '0;
			slot_r    <= 4'(slots - 4'h1);
			shift_r   <= '0;
		end
		else if (tick)
		begin
			bit_cnt_r <= '0;
			slot_r    <= last_slot ? 4'h0 : 4'(slot_r + 4'h1);
			shift_r   <= shift_nxt; // [R11]
		end
		else
			bit_cnt_r <= BC_W'(bit_cnt_r + 1'b1);
	end

	// line drivers: on = current flows, lvl 1 = high (1I), 0 = low (5I)
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			link_clock_line_on_out  <= 1'b0;
			link_clock_line_lvl_out <= 1'b0;
			link_data_line_on_out   <= 3'h0;
			link_data_line_lvl_out  <= 3'h0;
		end
		else
		begin
			case (ph_eff)
				PH_LOW1:
				begin
					link_clock_line_on_out  <= 1'b1; // [R3] [R13]
					link_clock_line_lvl_out <= 1'b0;
					link_data_line_on_out   <= 3'h0; // [R17]
					link_data_line_lvl_out  <= 3'h0;
				end
				PH_HIGH:
				begin
					link_clock_line_on_out  <= 1'b1; // [R4] [R13]
					link_clock_line_lvl_out <= 1'b1;
					link_data_line_on_out   <= 3'h0; // [R17]
					link_data_line_lvl_out  <= 3'h0;
				end
				PH_LOW2, PH_LOCK:
				begin
					link_clock_line_on_out  <= 1'b1; // [R5] [R6]
					link_clock_line_lvl_out <= 1'b0;
					link_data_line_on_out   <= lane_mask; // [R17]
					link_data_line_lvl_out  <= 3'h0;
				end
				PH_ACTIVE:
				begin
					link_clock_line_on_out <= 1'b1;
					link_data_line_on_out  <= lane_mask;
					if (tick)
					begin
						link_clock_line_lvl_out <= !link_clock_line_lvl_out;
						link_data_line_lvl_out  <=
							lane_bits(shift_nxt, three_r); // [R14]
					end
				end
				default:
				begin
					link_clock_line_on_out  <= 1'b0; // [R1]
					link_clock_line_lvl_out <= 1'b0;
					link_data_line_on_out   <= 3'h0;
					link_data_line_lvl_out  <= 3'h0;
				end
			endcase
		end
	end

	// status outputs
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			link_phase_out <= PHASE_OFF;
			bias_en_out    <= 1'b0;
			low_power_out  <= 1'b1;
		end
		else
		begin
			bias_en_out   <= (ph_eff != PH_OFF); // [R2]
			low_power_out <= link_down; // [R10]
			case (ph_eff)
				PH_OFF:    link_phase_out <= PHASE_OFF;
				PH_ACTIVE: link_phase_out <= PHASE_ACTIVE;
				default:   link_phase_out <= PHASE_LINKUP; // [R7]
			endcase
		end
	end
endmodule

// ### tb/link_seq_sva.sv
// port-level assertion checker for the pixel link sequencer
`timescale 1ns/1ps
module link_seq_sva
	import link_seq_pkg::*;
#(
	parameter int STOP_GAP = STOP_GAP_CYC
) (
	input wire logic       mclk_in,
	input wire logic       arst_n_in,
	input wire logic       pclk_in,
	input wire logic       power_down_n_in,
	input wire logic       three_lane_in,
	input wire logic       link_clock_line_on_out,
	input wire logic       link_clock_line_lvl_out,
	input wire logic [2:0] link_data_line_on_out,
	input wire logic [2:0] link_data_line_lvl_out,
	input wire logic [1:0] link_phase_out,
	input wire logic       bias_en_out,
	input wire logic       low_power_out,
	input wire logic       overflow_out
);
	int   gap_cnt_r;
	logic pclk_q_r;

	// mclk cycles since the last pixel clock edge, saturating
	always_ff @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			pclk_q_r  <= 1'b0;
			gap_cnt_r <= 0;
		end
		else
		begin
			pclk_q_r <= pclk_in;
			if (pclk_in != pclk_q_r)
				gap_cnt_r <= 0;
			else if (gap_cnt_r < STOP_GAP + 12)
				gap_cnt_r <= gap_cnt_r + 1;
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!arst_n_in);

	// margin of three cycles: phase and lines are registered together from ph_eff
	chk_off_lines_quiet: assert property (
		(link_phase_out == PHASE_OFF)[*4] |->
		!link_clock_line_on_out && link_data_line_on_out == 3'h0)
		else $error("line current while link is off");
	chk_bias_lines_off: assert property (
		$rose(bias_en_out) |-> (!link_clock_line_on_out)[*8])
		else $error("clock line on during bias interval");
	chk_phase_order: assert property (
		$changed(link_phase_out) |-> link_phase_out == PHASE_OFF ||
		link_phase_out == $past(link_phase_out) + 2'h1)
		else $error("illegal phase step");
	chk_down_lines_off: assert property (
		$rose(low_power_out) |-> ##[0:3]
		(link_phase_out == PHASE_OFF && !link_clock_line_on_out))
		else $error("low power without link off");
	chk_pd_low_power: assert property (
		$fell(power_down_n_in) |-> ##[1:5] low_power_out)
		else $error("power-down not followed by low power");
	chk_stop_resets: assert property (
		gap_cnt_r == STOP_GAP + 12 |->
		low_power_out && link_phase_out == PHASE_OFF)
		else $error("stopped pixel clock not detected");
	chk_two_lane_idle: assert property (
		!three_lane_in && link_phase_out == PHASE_ACTIVE |->
		!link_data_line_on_out[2])
		else $error("third lane on in two-lane mode");
	chk_data_on_edges: assert property (
		link_clock_line_on_out && link_phase_out == PHASE_ACTIVE &&
		$changed(link_data_line_lvl_out) |->
		$changed(link_clock_line_lvl_out))
		else $error("data moved without a clock line edge");
	chk_low2_data_on: assert property (
		link_clock_line_on_out && $fell(link_clock_line_lvl_out) |->
		link_data_line_on_out[1:0] == 2'h3)
		else $error("data lanes off after clock line fall");

	cover property (link_phase_out == PHASE_ACTIVE);
	cover property ($rose(overflow_out));
	cover property ($rose(low_power_out) && power_down_n_in);
endmodule

bind serial_pixel_link_phase_sequencer link_seq_sva #(.STOP_GAP(STOP_GAP))
	chk_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .pclk_in(pclk_in),
	.power_down_n_in(power_down_n_in), .three_lane_in(three_lane_in),
	.link_clock_line_on_out(link_clock_line_on_out),
	.link_clock_line_lvl_out(link_clock_line_lvl_out),
	.link_data_line_on_out(link_data_line_on_out),
	.link_data_line_lvl_out(link_data_line_lvl_out),
	.link_phase_out(link_phase_out), .bias_en_out(bias_en_out),
	.low_power_out(low_power_out), .overflow_out(overflow_out));

// ### tb/link_rx_model.sv
// behavioural far-end receiver for the pixel link
`timescale 1ns/1ps
module link_rx_model (
	input  wire logic        mclk_in,
	input  wire logic        three_lane_in,
	input  wire logic        clk_on_in,
	input  wire logic        clk_lvl_in,
	input  wire logic [2:0]  dat_lvl_in,
	output logic      [23:0] rx_word_out,
	output logic             rx_valid_out,
	output logic      [31:0] low1_len_out,
	output logic      [31:0] high_len_out,
	output logic      [31:0] low2_len_out,
	output logic             powered_out,
	output logic             calibrated_out
);
	logic        lvl_r;
	logic [31:0] run_r;
	logic [3:0]  slot_r;
	logic [23:0] word_r;
	logic [23:0] nxt;

	// a tick is any clock line level change; a steady cycle drops the slot
	always @(posedge mclk_in)
	begin
		lvl_r <= clk_lvl_in;
		rx_valid_out <= 1'b0;
		if (!clk_on_in)
		begin
			powered_out <= 1'b0;
			calibrated_out <= 1'b0;
			run_r <= 0;
			slot_r <= 4'h0;
			low1_len_out <= 0;
			high_len_out <= 0;
			low2_len_out <= 0;
		end
		else if (clk_lvl_in == lvl_r)
		begin
			run_r <= run_r + 1;
			slot_r <= 4'h0;
			if (!clk_lvl_in)
				powered_out <= 1'b1;
		end
		else
		begin
			run_r <= 1;
			if (clk_lvl_in && !calibrated_out)
			begin
				low1_len_out <= run_r;
				calibrated_out <= 1'b1;
			end
			else if (clk_lvl_in && run_r > 1)
				low2_len_out <= run_r;
			else if (!clk_lvl_in && run_r > 1)
				high_len_out <= run_r;
			nxt = three_lane_in ?
				{word_r[20:0], dat_lvl_in[0], dat_lvl_in[1], dat_lvl_in[2]} :
				{word_r[21:0], dat_lvl_in[0], dat_lvl_in[1]};
			word_r <= nxt;
			slot_r <= slot_r + 4'h1;
			if (slot_r == (three_lane_in ? 4'h7 : 4'hb))
			begin
				rx_word_out <= nxt;
				rx_valid_out <= 1'b1;
				slot_r <= 4'h0;
			end
		end
	end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the pixel link sequencer
`timescale 1ns/1ps
module tb_top
	import link_seq_pkg::*;
;
	localparam int PCLK_NS = 30;
	logic mclk, arst_n, pclk, pclk_run, pd_n, three_lane, vs, hs, pv;
	logic [7:0]  red, green, blue;
	logic        ck_on, ck_lvl, bias_en, low_pwr, ovf, rx_valid;
	logic [2:0]  d_on, d_lvl;
	logic [1:0]  phase;
	logic        rx_pwr, rx_cal;
	logic [23:0] rx_word, e, last_rx;
	logic [31:0] low1_len, high_len, low2_len, seed;
	logic [23:0] exp_q[$];
	int          num_errors, check_count, cyc, bias_cnt, bias_len;

	serial_pixel_link_phase_sequencer #(.STOP_GAP(20)) dut_u (
		.mclk_in(mclk), .arst_n_in(arst_n), .pclk_in(pclk),
		.power_down_n_in(pd_n), .three_lane_in(three_lane),
		.red_in(red), .green_in(green), .blue_in(blue),
		.vertical_sync_in(vs), .horizontal_sync_in(hs),
		.pixel_valid_in(pv), .link_clock_line_on_out(ck_on),
		.link_clock_line_lvl_out(ck_lvl), .link_data_line_on_out(d_on),
		.link_data_line_lvl_out(d_lvl), .link_phase_out(phase),
		.bias_en_out(bias_en), .low_power_out(low_pwr),
		.overflow_out(ovf));

	link_rx_model far_u (
		.mclk_in(mclk), .three_lane_in(three_lane), .clk_on_in(ck_on),
		.clk_lvl_in(ck_lvl), .dat_lvl_in(d_lvl), .rx_word_out(rx_word),
		.rx_valid_out(rx_valid), .low1_len_out(low1_len),
		.high_len_out(high_len), .low2_len_out(low2_len),
		.powered_out(rx_pwr), .calibrated_out(rx_cal));

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// pixel clock keeps its level while stopped
	initial
	begin
		pclk = 1'b0;
		#3;
		forever #15 pclk = pclk_run ? ~pclk : pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// within three mclk of the given pixel clock count
	function automatic logic [31:0] near(input int seen, input int pclks);
		int mid;
		mid = pclks * PCLK_NS / MCLK_PERIOD_NS;
		return {31'h0, seen >= mid - 3 && seen <= mid + 3};
	endfunction

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			conclude();
		end
		if (!bias_en)
			bias_len <= 0;
		if (!bias_en || ck_on)
			bias_cnt <= 0;
		else
			bias_cnt <= bias_cnt + 1;
		if (bias_en && ck_on && bias_cnt != 0)
			bias_len <= bias_cnt;
		if (rx_valid)
			last_rx <= rx_word;
		// a held pixel may pass the fifo up to four times; repeats count once
		if (rx_valid && rx_word !== 24'h0 && rx_word !== last_rx)
		begin
			e = exp_q.size() ? exp_q.pop_front() : 24'hx;
			check(rx_word, e);
		end
	end

	task automatic startup;
		int n;
		n = 0;
		while (phase !== PHASE_ACTIVE && n < 6000)
		begin
			@(posedge mclk);
			n++;
		end
		repeat (10) @(posedge mclk);
		check(phase, PHASE_ACTIVE);
		check(near(bias_len, 200), 1);
		check(near(low1_len, 200), 1);
		check(near(high_len, 20), 1);
		check(near(low2_len, 608), 1);
		check({rx_pwr, rx_cal}, 2'h3);
	endtask

	// the fifo already holds idle words and fills during the burst; each pixel is held four
	// pixel clocks so at least one copy gets in before the next
	task automatic burst;
		logic [31:0] r;
		repeat (2) @(negedge pclk);
		for (int i = 0; i < 7; i++)
		begin
			r = (i < 6) ? rnd() : 32'h0;
			{vs, hs, blue, green, red} = r[25:0];
			pv = (i < 6);
			if (i < 6)
				exp_q.push_back({red[7:2], green[7:2], blue[7:2], vs, hs, 4'h8});
			repeat (4) @(negedge pclk);
		end
		repeat (40) @(negedge pclk);
		check(exp_q.size(), 0);
		check(ovf, 1);
	endtask

	task automatic off_checks;
		check(low_pwr, 1);
		check(phase, PHASE_OFF);
		check({bias_en, ck_on, d_on}, 5'h0);
	endtask

	initial
	begin
		seed = 32'h9;
		{arst_n, pd_n, three_lane, pclk_run, pv, vs, hs} = 7'h38;
		{red, green, blue} = 24'h0;
		last_rx = 24'h0;
		{num_errors, check_count, cyc, bias_cnt, bias_len} = '0;
		repeat (4) @(negedge mclk);
		off_checks();
		arst_n = 1'b1;
		startup();
		burst();
		@(negedge mclk);
		pd_n = 1'b0;
		repeat (8) @(negedge mclk);
		off_checks();
		check(ovf, 0);
		three_lane = 1'b0;
		pd_n = 1'b1;
		startup();
		burst();
		@(negedge pclk);
		pclk_run = 1'b0;
		repeat (45) @(negedge mclk);
		off_checks();
		pclk_run = 1'b1;
		startup();
		burst();
		conclude();
	end
endmodule
